// file: src/ubsm_pkg.sv
package ubsm_pkg;
    // ------------------------------------------------------------
    // register map (plain port, byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_SERIAL_BUFFER = 4'h0; // tx write / rx read
    localparam logic [3:0] ADDR_SERIAL_CONTROL = 4'h1; // mode, enables, flags
    localparam logic [3:0] ADDR_POWER_CONTROL = 4'h2; // rate doubling
    localparam logic [3:0] ADDR_TIMER_RELOAD = 4'h3; // reload value of rate timer
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CTL_RX_COMPLETE = 0;
    localparam int CTL_TX_COMPLETE = 1;
    localparam int CTL_RX_NINTH = 2;
    localparam int CTL_RX_ENABLE = 4;
    localparam int CTL_QUALIFY = 5;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_FRAME_ERR = 7;
    localparam int PWR_DOUBLE = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] PWR_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    // ------------------------------------------------------------
    // timing constants
    // ------------------------------------------------------------
    localparam logic [2:0] STATES_PER_CYCLE = 3'h6; // six states S1..S6
    localparam logic [4:0] FIXED_DIV_SLOW = 5'h03; // 4 clocks per 16th bit: cpu/32
    localparam logic [4:0] FIXED_DIV_FAST = 5'h01; // 2 clocks per 16th bit: cpu/16
    localparam logic [8:0] RX_ASYNC_PRESET = 9'h1FF;
    localparam logic [8:0] RX_SHIFT_PRESET = 9'h0FE; // 11111110 in shift mode
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        UBSM_MODE_SHIFT = 2'b00,
        UBSM_MODE_ASYNC8 = 2'b01,
        UBSM_MODE_FIXED9 = 2'b10,
        UBSM_MODE_VAR9 = 2'b11
    } ubsm_mode_t;
    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ubsm_bus_t;
endpackage

// file: src/ubsm_phase.sv
`timescale 1ns/1ns
`default_nettype none
// machine-cycle state counter: s_state 1..6, two phases each
module ubsm_phase
    import ubsm_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_enable,
    output logic [2:0] o_state,
    output logic o_phase2
);
    // ------------------------------------------------------------
    // state / phase sequencer
    // ------------------------------------------------------------
    wire logic [2:0] next_state = (o_state == STATES_PER_CYCLE) ? 3'h1 : o_state + 3'h1;
    // one clock per phase, so a machine cycle is twelve clocks
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            o_state <= 3'h1;
            o_phase2 <= 1'b0;
        end
        else if (i_enable)
        begin
            o_phase2 <= ~o_phase2;
            if (o_phase2)
                o_state <= next_state;
        end
    end
endmodule
`default_nettype wire

// file: src/ubsm_vote.sv
`timescale 1ns/1ns
`default_nettype none
// three-sample majority bit detector
module ubsm_vote
    import ubsm_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_enable,
    input wire logic i_tick,
    input wire logic [3:0] i_count,
    input wire logic i_line,
    output logic o_bit
);
    // ------------------------------------------------------------
    // samples at counter states 7,8,9
    // ------------------------------------------------------------
    logic [2:0] samples; // three captured line values
    wire logic take = i_tick && (i_count == SAMPLE_A || i_count == SAMPLE_B
        || i_count == SAMPLE_C);
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            samples <= 3'h7;
        else if (i_enable && take)
            samples <= {samples[1:0], i_line};
    end
    // majority of three rejects a single noise spike
    assign o_bit = (samples[0] & samples[1]) | (samples[1] & samples[2])
        | (samples[0] & samples[2]);
endmodule
`default_nettype wire

// file: src/ubsm_uart.sv
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - shift mode: bit rate cpu/6
// - fixed 9-bit rate cpu/32 or cpu/16
// - variable rate follows timer overflow, doubling
// - shift mode: 8 bits LSB first on rx
// - shift tx write loads marker, send later
// - shift clock low S3-S5, shift S6P2
// - zero fill, marker ends send, flag
// - shift rx starts: enabled, flag clear
// - rx clock toggles, sample S5P2, shift S6P2
// - final rx shift loads buffer, flag
// - async frame start, 8 data, stop
// - async tx starts after counter rollover
// - start bit, then data, then shifts
// - marker reaches bit 0 (shift) or bit 1 (async): end, set flag
// - falling edge resets counter, presets 1FF
// - majority of samples 7, 8, 9
// - false start bit restarts hunting
// - nine-bit rx register, start reaches left
// - store only if flag clear, qualified
// - after final shift resume hunting
// - async rx needs receive enable
// - framing error sticky until cleared
// - double buffered, held while flag set
module ubsm_uart
    import ubsm_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_enable,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_rxd_in,
    output logic o_rxd_out,
    output logic o_rxd_oe_n,
    output logic o_txd
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    ubsm_bus_t bus; // grouped register request
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    wire logic wr_buf = bus.wr && bus.addr == ADDR_SERIAL_BUFFER;
    wire logic wr_ctl = bus.wr && bus.addr == ADDR_SERIAL_CONTROL;
    wire logic wr_pwr = bus.wr && bus.addr == ADDR_POWER_CONTROL;
    wire logic wr_rel = bus.wr && bus.addr == ADDR_TIMER_RELOAD;
    // ------------------------------------------------------------
    // software state
    // ------------------------------------------------------------
    logic [7:0] ctl; // serial_control_reg
    logic [7:0] pwr; // power_control_reg
    logic [7:0] reload; // rate timer reload value
    logic [7:0] serial_buffer; // receive holding register
    logic tx_complete_flag;
    logic rx_complete_flag;
    logic rx_ninth_bit;
    logic framing_error_flag;
    wire ubsm_mode_t mode = ubsm_mode_t'({ctl[CTL_FRAME_ERR], ctl[CTL_MODE_LO]});
    wire logic baud_double_select = pwr[PWR_DOUBLE];
    wire logic rx_qualify_bit = ctl[CTL_QUALIFY];
    wire logic rx_en = ctl[CTL_RX_ENABLE];
    // ------------------------------------------------------------
    // machine cycle timing
    // ------------------------------------------------------------
    logic [2:0] st; // current S state
    logic p2; // high in phase 2
    ubsm_phase u_phase
    (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_enable(i_enable),
        .o_state(st),
        .o_phase2(p2)
    );
    wire logic s6p2 = st == 3'h6 && p2;
    wire logic s1p1 = st == 3'h1 && !p2;
    wire logic s5p2 = st == 3'h5 && p2;
    // ------------------------------------------------------------
    // rate timer and 16x tick
    // ------------------------------------------------------------
    // the timer counts machine cycles, 8-bit auto reload
    logic [7:0] tmr;
    logic half; // overflow halving when not doubled
    logic [4:0] fixdiv; // fixed-rate prescaler
    wire logic tmr_ovf = s6p2 && tmr == 8'hFF;
    wire logic var_tick = tmr_ovf && (baud_double_select || half);
    wire logic fix_tick = fixdiv == 5'h00;
    wire logic tick = (mode == UBSM_MODE_FIXED9) ? fix_tick : var_tick;
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            tmr <= RELOAD_RESET;
            half <= 1'b0;
            fixdiv <= FIXED_DIV_SLOW;
        end
        else if (i_enable)
        begin
            if (s6p2)
                tmr <= (tmr == 8'hFF) ? reload : tmr + 8'h01;
            if (tmr_ovf)
                half <= ~half;
            // two clocks per cpu clock period: divider counts phases
            if (fix_tick)
                fixdiv <= baud_double_select ? FIXED_DIV_FAST : FIXED_DIV_SLOW;
            else
                fixdiv <= fixdiv - 5'h01;
        end
    end
    // ------------------------------------------------------------
    // transmit divide-by-16 counter (free running)
    // ------------------------------------------------------------
    logic [3:0] txcnt;
    wire logic tx_roll = tick && txcnt == 4'hF;
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            txcnt <= 4'h0;
        else if (i_enable && tick)
            txcnt <= txcnt + 4'h1;
    end
    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    logic [DATA_W:0] txsr; // marker plus data
    logic tx_req; // write seen, waiting to start
    logic tx_pend; // shift mode one-cycle delay
    logic send; // send phase
    logic data_on; // async data drive
    wire logic tx_last = txsr[DATA_W:1] == {{(DATA_W-1){1'b0}}, 1'b1};
    wire logic async = mode != UBSM_MODE_SHIFT;
    // marker alone at the output: the final shift has just happened
    wire logic tx_done_sh = send && !async && s1p1 && txsr == (DATA_W+1)'(1);
    wire logic tx_done_as = send && async && tx_roll && data_on && tx_last;
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            txsr <= '0;
            tx_req <= 1'b0;
            tx_pend <= 1'b0;
            send <= 1'b0;
            data_on <= 1'b0;
        end
        else if (i_enable)
        begin
            if (wr_buf)
            begin
                txsr <= {1'b1, bus.wdata}; // marker into ninth place
                tx_req <= 1'b1;
                send <= 1'b0;
                data_on <= 1'b0;
            end
            else if (!async)
            begin
                // write stands at S6P2; send a full cycle later
                if (tx_req && s6p2)
                begin
                    tx_req <= 1'b0;
                    tx_pend <= 1'b1;
                end
                else if (tx_pend && s6p2)
                begin
                    tx_pend <= 1'b0;
                    send <= 1'b1;
                end
                else if (send && s6p2)
                    txsr <= {1'b0, txsr[DATA_W:1]}; // shift right, zero fill
                if (tx_done_sh)
                    send <= 1'b0;
            end
            else if (tx_roll)
            begin
                if (tx_req)
                begin
                    tx_req <= 1'b0;
                    send <= 1'b1; // start bit
                end
                else if (send && !data_on)
                    data_on <= 1'b1;
                else if (tx_done_as)
                begin
                    send <= 1'b0;
                    data_on <= 1'b0;
                end
                else if (send)
                    txsr <= {1'b0, txsr[DATA_W:1]};
            end
        end
    end
    // shift clock: low S3..S5, high S6,S1,S2
    wire logic shclk = !(st == 3'h3 || st == 3'h4 || st == 3'h5);
    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    logic [DATA_W:0] rxsr;
    logic rx_arm; // shift-mode start pending
    logic rx_act; // receive phase
    logic rx_samp; // pin sampled at S5P2
    logic rx_prev; // previous line for edge hunt
    logic [3:0] rxcnt; // receive divide-by-16
    logic rx_first; // still in start bit time
    logic rx_bit; // voted bit
    ubsm_vote u_vote
    (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_enable(i_enable),
        .i_tick(tick),
        .i_count(rxcnt),
        .i_line(i_rxd_in),
        .o_bit(rx_bit)
    );
    wire logic fall = async && rx_en && !rx_act && rx_prev && !i_rxd_in;
    wire logic rx_roll = tick && rxcnt == 4'hF && rx_act;
    wire logic rx_fin_sh = !async && rx_act && s6p2 && !rxsr[DATA_W-1];
    wire logic rx_fin_as = async && rx_roll && !rx_first && !rxsr[DATA_W];
    // store only when flag clear and stop qualifies
    wire logic rx_store = rx_fin_as && !rx_complete_flag && (!rx_qualify_bit || rx_bit);
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            rxsr <= '1;
            rx_arm <= 1'b0;
            rx_act <= 1'b0;
            rx_samp <= 1'b1;
            rx_prev <= 1'b1;
            rxcnt <= 4'h0;
            rx_first <= 1'b0;
        end
        else if (i_enable)
        begin
            rx_prev <= i_rxd_in;
            if (s5p2)
                rx_samp <= i_rxd_in;
            if (!async)
            begin
                if (!rx_act && !rx_arm && rx_en && !rx_complete_flag)
                    rx_arm <= 1'b1;
                else if (rx_arm && s6p2)
                begin
                    rxsr <= RX_SHIFT_PRESET;
                    rx_arm <= 1'b0;
                    rx_act <= 1'b1;
                end
                else if (rx_act && s6p2)
                begin
                    rxsr <= {rxsr[DATA_W-1:0], rx_samp};
                    if (rx_fin_sh)
                        rx_act <= 1'b0;
                end
            end
            else if (fall)
            begin
                rxcnt <= 4'h0;
                rxsr <= RX_ASYNC_PRESET;
                rx_act <= 1'b1;
                rx_first <= 1'b1;
            end
            else if (rx_act && tick)
            begin
                rxcnt <= rxcnt + 4'h1;
                if (rx_roll)
                begin
                    if (rx_first && rx_bit)
                        rx_act <= 1'b0; // false start
                    else if (rx_fin_as)
                        rx_act <= 1'b0; // hunt again
                    else
                        rxsr <= {rxsr[DATA_W-1:0], rx_bit};
                    rx_first <= 1'b0;
                end
            end
        end
    end
    // ------------------------------------------------------------
    // flags and holding register (set wins over clear)
    // ------------------------------------------------------------
    wire logic set_ti = tx_done_sh || tx_done_as;
    wire logic set_ri = rx_fin_sh || rx_store;
    wire logic set_fe = rx_fin_as && !rx_bit;
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            ctl <= CTL_RESET;
            pwr <= PWR_RESET;
            reload <= RELOAD_RESET;
            serial_buffer <= 8'h00;
            tx_complete_flag <= 1'b0;
            rx_complete_flag <= 1'b0;
            rx_ninth_bit <= 1'b0;
            framing_error_flag <= 1'b0;
        end
        else if (i_enable)
        begin
            if (wr_ctl)
            begin
                ctl <= bus.wdata;
                tx_complete_flag <= bus.wdata[CTL_TX_COMPLETE];
                rx_complete_flag <= bus.wdata[CTL_RX_COMPLETE];
                rx_ninth_bit <= bus.wdata[CTL_RX_NINTH];
                framing_error_flag <= framing_error_flag & bus.wdata[CTL_FRAME_ERR];
            end
            if (wr_pwr)
                pwr <= bus.wdata;
            if (wr_rel)
                reload <= bus.wdata;
            if (set_ti)
                tx_complete_flag <= 1'b1;
            if (rx_fin_sh)
                serial_buffer <= {<<{rxsr[DATA_W-2:0], rx_samp}}; // first bit is lsb
            if (set_ri)
                rx_complete_flag <= 1'b1;
            if (rx_store)
            begin
                serial_buffer <= {<<{rxsr[DATA_W-1:0]}}; // replaces byte once flag cleared
                rx_ninth_bit <= rx_bit; // stop bit
            end
            if (set_fe)
                framing_error_flag <= 1'b1; // sticky
        end
    end
    // ------------------------------------------------------------
    // pins and read data (registered)
    // ------------------------------------------------------------
    wire logic [7:0] ctl_view = {framing_error_flag, ctl[6:3], rx_ninth_bit,
        tx_complete_flag, rx_complete_flag};
    wire logic [7:0] rd_mux = (bus.addr == ADDR_SERIAL_BUFFER) ? serial_buffer :
        (bus.addr == ADDR_SERIAL_CONTROL) ? ctl_view :
        (bus.addr == ADDR_POWER_CONTROL) ? pwr :
        (bus.addr == ADDR_TIMER_RELOAD) ? reload : 8'h00;
    wire logic sh_tx = !async && send;
    wire logic next_txd = async ? (!send || (data_on && txsr[0])) :
        ((sh_tx || rx_act) ? shclk : 1'b1);
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            o_rdata <= 8'h00;
            o_txd <= 1'b1;
            o_rxd_out <= 1'b1;
            o_rxd_oe_n <= 1'b1;
        end
        else if (i_enable)
        begin
            o_rdata <= bus.rd ? rd_mux : 8'h00;
            o_txd <= next_txd;
            o_rxd_out <= txsr[0];
            o_rxd_oe_n <= !sh_tx;
        end
    end
endmodule
`default_nettype wire

// file: test/ubsm_uart_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ubsm_uart_chk
    import ubsm_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_enable,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_rxd_in,
    input wire logic o_rxd_out,
    input wire logic o_rxd_oe_n,
    input wire logic o_txd
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    // ------
    // helper state
    // ------
    logic [1:0] mode; // mode field last written
    logic [3:0] falls; // shift clock falls in one send
    logic [7:0] low_run; // clocks the rx pin has been driven
    wire logic ctl_wr = i_enable && i_wr && i_addr == ADDR_SERIAL_CONTROL;
    wire logic buf_wr = i_enable && i_wr && i_addr == ADDR_SERIAL_BUFFER;
    // mode and shape of each shift-mode send
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            mode <= 2'h0;
            falls <= 4'h0;
            low_run <= 8'h00;
        end
        else
        begin
            if (ctl_wr)
                mode <= i_wdata[7:6];
            if ($fell(o_rxd_oe_n))
                falls <= 4'h0;
            else if (!o_rxd_oe_n && $fell(o_txd))
                falls <= falls + 4'h1;
            low_run <= o_rxd_oe_n ? 8'h00 : low_run + 8'h01;
        end
    end
    // ------
    // checks
    // ------
    AST_RESET_IDLE: assert property ($rose(i_nrst) |-> o_txd && o_rxd_oe_n && o_rdata == 8'h00)
        else $error("outputs not idle after reset");
    AST_RDATA_QUIET: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its slot");
    AST_UNMAPPED_ZERO: assert property ($past(i_rd) && $past(i_addr) > ADDR_TIMER_RELOAD
        |-> o_rdata == 8'h00) else $error("unmapped read not zero");
    AST_SEND_START: assert property (
        buf_wr && mode == 2'h0 && o_rxd_oe_n |-> ##[6:30] !o_rxd_oe_n)
        else $error("shift send did not start");
    AST_TX_CLK_LOW: assert property (
        $fell(o_txd) && !o_rxd_oe_n |=> !o_txd [*5] ##1 o_txd)
        else $error("send clock low phase wrong");
    AST_TX_CLK_HIGH: assert property ($rose(o_txd) && !o_rxd_oe_n |=> o_txd [*5])
        else $error("send clock high phase wrong");
    AST_RX_CLK: assert property (
        $fell(o_txd) && o_rxd_oe_n && mode == 2'h0 |=> !o_txd [*5] ##1 o_txd)
        else $error("receive clock phase wrong");
    AST_EIGHT_BITS: assert property ($rose(o_rxd_oe_n) |-> falls == 4'h8)
        else $error("send clock count not eight");
    AST_SEND_LEN: assert property (
        $rose(o_rxd_oe_n) |-> low_run inside {[8'h54:8'h6E]})
        else $error("send length wrong");
    AST_RX_START: assert property (
        ctl_wr && i_wdata[7:6] == 2'h0 && i_wdata[4] && !i_wdata[0] |-> ##[2:40] !o_txd)
        else $error("shift receive did not start");
    COV_SEND: cover property ($rose(o_rxd_oe_n));
    COV_ASYNC: cover property (mode == 2'h1 && $fell(o_txd));
    COV_UNMAPPED: cover property (i_rd && i_addr > ADDR_TIMER_RELOAD);
endmodule
bind ubsm_uart ubsm_uart_chk #(.DATA_W(DATA_W)) i_ubsm_uart_chk (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_enable(i_enable), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd_in(i_rxd_in), .o_rxd_out(o_rxd_out),
    .o_rxd_oe_n(o_rxd_oe_n), .o_txd(o_txd));
`default_nettype wire

// file: test/ubsm_peer.sv
`timescale 1ns/1ns
`default_nettype none
module ubsm_peer
    import ubsm_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sync, // act as shift register when high
    input wire logic i_txd, // line or shift clock from the block
    input wire logic i_rxd, // resolved rx pin
    input wire logic i_oe_n, // low while the block drives rx pin
    output logic o_line, // our drive onto rx pin
    output logic [7:0] o_cap // last byte shifted out by the block
);
    logic [7:0] pat; // bits still to present
    logic clk_q; // shift clock at last edge
    initial
    begin
        o_line = 1'b1;
        o_cap = 8'h00;
        pat = 8'hFF;
        clk_q = 1'b1;
    end
    // shift-register partner: next bit on rising clock, capture mid-bit
    always @(posedge i_clock)
    begin
        clk_q <= i_txd;
        if (i_sync && i_oe_n && i_txd && !clk_q)
        begin
            o_line <= pat[0];
            pat <= {~pat[0], pat[7:1]}; // stale tail toggles, never holds
        end
        if (i_sync && !i_oe_n && !i_txd && clk_q)
            o_cap <= {i_rxd, o_cap[7:1]};
    end
    // first bit must stand before the first sample
    task automatic load(input logic [7:0] d);
        o_line <= d[0];
        pat <= {~d[0], d[7:1]};
    endtask
    // optional short false start, then one framed byte
    task automatic send(input int bt, input logic [7:0] d, input logic stp, input int glitch);
        logic [9:0] fr;
        fr = {stp, d, 1'b0}; // start, data lsb first, stop
        o_line <= 1'b0;
        repeat (glitch) @(posedge i_clock);
        o_line <= 1'b1;
        repeat (2 * bt) @(posedge i_clock);
        for (int i = 0; i < 10; i++)
        begin
            o_line <= fr[i];
            repeat (bt) @(posedge i_clock);
        end
        o_line <= 1'b1; // mark level when idle
    endtask
    // sample a frame from the block at bit centres
    task automatic get(input int bt, output logic [9:0] fr);
        fr = 10'h000;
        while (i_txd !== 1'b0)
            @(posedge i_clock);
        repeat (bt / 2) @(posedge i_clock);
        for (int i = 0; i < 10; i++)
        begin
            fr[i] = i_txd;
            repeat (bt) @(posedge i_clock);
        end
    endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("[FAIL] %0t got %0h want %0h", $time, (got), (exp)); \
        end \
    end
module tb
    import ubsm_pkg::*;
;
    logic clock, nrst, bus_wr, bus_rd, sync; // bench drives
    logic [3:0] addr; // register address
    logic [7:0] wdata; // register write data
    logic [7:0] rdata, peer_cap; // design read data, partner capture
    logic rxd_out, oe_n, txd, peer_line; // pin side
    wire logic rxd_pin = oe_n ? peer_line : rxd_out; // resolved rx pin
    int n_fail = 0, compares = 0, cyc = 0;
    ubsm_uart #(.DATA_W(8)) i_ubsm_uart (.i_clock(clock), .i_nrst(nrst), .i_enable(1'b1),
        .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata),
        .i_rxd_in(rxd_pin), .o_rxd_out(rxd_out), .o_rxd_oe_n(oe_n), .o_txd(txd));
    ubsm_peer i_ubsm_peer (.i_clock(clock), .i_sync(sync), .i_txd(txd), .i_rxd(rxd_pin),
        .i_oe_n(oe_n), .o_line(peer_line), .o_cap(peer_cap));
    // ------
    // bus tasks and verdict
    // ------
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic poll(input int b);
        logic [7:0] d;
        d = 8'h00;
        for (int n = 0; n < 4000 && d[b] !== 1'b1; n++)
            reg_rd(ADDR_SERIAL_CONTROL, d);
    endtask
    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // hang guard: longest run is well under this
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    // ------
    // scenarios
    // ------
    initial
    begin
        logic [7:0] d;
        logic [9:0] fr;
        int bt;
        logic [7:0] rel [2] = '{8'hFF, 8'hFE};
        logic [7:0] pwr [2] = '{8'h80, 8'h00};
        logic [7:0] dat [2] = '{8'hA5, 8'h3C};
        logic [7:0] rctl [5] = '{8'h50, 8'h70, 8'h40, 8'h51, 8'h50};
        logic [7:0] rdat [5] = '{8'h3C, 8'h99, 8'h11, 8'h77, 8'hC3};
        logic [7:0] rbuf [5] = '{8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'hC3};
        logic [4:0] rstp = 5'b01101;
        logic [4:0] rflg = 5'b11001;
        nrst = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        sync = 1'b1;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        reg_rd(ADDR_SERIAL_CONTROL, d);
        `CHK(d, CTL_RESET)
        reg_rd(ADDR_POWER_CONTROL, d);
        `CHK(d, PWR_RESET)
        reg_rd(ADDR_TIMER_RELOAD, d);
        `CHK(d, RELOAD_RESET)
        reg_wr(4'hF, 8'h5A);
        reg_rd(4'hF, d);
        `CHK(d, 8'h00)
        // shift mode send, then receive
        reg_wr(ADDR_SERIAL_CONTROL, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            reg_wr(ADDR_SERIAL_BUFFER, dat[i]);
            poll(CTL_TX_COMPLETE);
            `CHK(peer_cap, dat[i])
            reg_wr(ADDR_SERIAL_CONTROL, 8'h00);
        end
        i_ubsm_peer.load(8'h96);
        reg_wr(ADDR_SERIAL_CONTROL, 8'h10);
        poll(CTL_RX_COMPLETE);
        reg_rd(ADDR_SERIAL_BUFFER, d);
        `CHK(d, 8'h96)
        // async send at two rates; rate timer has no interrupt in use
        sync <= 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            reg_wr(ADDR_TIMER_RELOAD, rel[i]);
            reg_rd(ADDR_TIMER_RELOAD, d);
            `CHK(d, rel[i])
            reg_wr(ADDR_POWER_CONTROL, pwr[i]);
            reg_wr(ADDR_SERIAL_CONTROL, 8'h40);
            bt = 192 * (256 - int'(rel[i])) * (pwr[i][PWR_DOUBLE] ? 1 : 2);
            reg_wr(ADDR_SERIAL_BUFFER, dat[i]);
            i_ubsm_peer.get(bt, fr);
            `CHK(fr, {1'b1, dat[i], 1'b0})
            poll(CTL_TX_COMPLETE);
            reg_rd(ADDR_SERIAL_CONTROL, d);
            `CHK(d[CTL_TX_COMPLETE], 1'b1)
        end
        // async receive: enable, qualify, full flag, bad stop
        reg_wr(ADDR_TIMER_RELOAD, 8'hFF);
        reg_wr(ADDR_POWER_CONTROL, 8'h80);
        bt = 192;
        for (int i = 0; i < 5; i++)
        begin
            reg_wr(ADDR_SERIAL_CONTROL, rctl[i]);
            i_ubsm_peer.send(bt, rdat[i], rstp[i], 48);
            repeat (bt) @(posedge clock);
            reg_rd(ADDR_SERIAL_CONTROL, d);
            `CHK(d[CTL_RX_COMPLETE], rflg[i])
            `CHK(d[CTL_FRAME_ERR], rctl[i][CTL_RX_ENABLE] & ~rstp[i])
            if (!rctl[i][CTL_RX_COMPLETE] && rflg[i])
                `CHK(d[CTL_RX_NINTH], rstp[i])
            reg_rd(ADDR_SERIAL_BUFFER, d);
            `CHK(d, rbuf[i])
        end
        wrap_up();
    end
endmodule
`default_nettype wire
